/* verilog/pemx_pkg.sv */
/*
 * Constants for the eight-bit bidirectional port with peripheral pin sharing.
 * Assumes a single system clock and synchronous active-high reset.
 */
package pemx_pkg;
   // ==================================================
   // Port geometry and reset values
   localparam int WIDTH = 8;
   localparam logic [7:0] DIR_RESET = 8'hFF;
   localparam logic [7:0] LATCH_RESET = 8'h00;
   localparam logic [7:0] LEVELS_RESET = 8'h00;
   localparam logic PULLUP_DIS_RESET = 1'h1;
   localparam logic OPEN_DRAIN_RESET = 1'h0;
   // ==================================================
   // Field positions
   localparam int PULLUP_DIS_BIT = 6;
   localparam int OPEN_DRAIN_BIT = 6;
   localparam int PIN_TOP = 7;
   localparam int PIN_REFCLK = 3;
   localparam int PIN_CS = 2;
   localparam int PIN_WR = 1;
   localparam int PIN_RD = 0;
   // ==================================================
   // Owner of each pin; the selector tests MEM first, then PSP, REF, PWM, CCP, and LATCH last.
   typedef enum logic [2:0] {
      PEMX_OWN_LATCH = 3'h0,
      PEMX_OWN_CCP = 3'h1,
      PEMX_OWN_PWM = 3'h3,
      PEMX_OWN_PSP = 3'h2,
      PEMX_OWN_REF = 3'h6,
      PEMX_OWN_MEM = 3'h7
   } pemx_owner_t;
endpackage : pemx_pkg

/* verilog/pemx_pin_sel.sv */
/*
 * One pad's output selector: picks the owner and forms drive and enable.
 * Assumes the owner request bits are already qualified by the top module.
 */
`timescale 1ns/1ps
`default_nettype none
module pemx_pin_sel (
   input wire logic i_dir,
   input wire logic i_latch,
   input wire logic i_mem_oe,
   input wire logic i_mem_out,
   input wire logic i_psp_own,
   input wire logic i_ref_own,
   input wire logic i_ref_out,
   input wire logic i_pwm_own,
   input wire logic i_pwm_out,
   input wire logic i_pwm_tristate,
   input wire logic i_ccp_own,
   input wire logic i_ccp_out,
   input wire logic i_open_drain,
   output pemx_pkg::pemx_owner_t o_owner,
   output logic o_out,
   output logic o_oe
);
   // Priority selection of the pad owner and its drive.
   always_comb begin
      o_owner = pemx_pkg::PEMX_OWN_LATCH;
      o_out = i_latch;
      o_oe = ~i_dir;
      if (i_mem_oe | i_mem_out) begin
         o_owner = pemx_pkg::PEMX_OWN_MEM;
         o_out = i_mem_out;
         o_oe = i_mem_oe;
      end else if (i_psp_own) begin
         o_owner = pemx_pkg::PEMX_OWN_PSP;
         o_out = 1'b0;
         o_oe = 1'b0;
      end else if (i_ref_own) begin
         o_owner = pemx_pkg::PEMX_OWN_REF;
         o_out = i_ref_out;
         o_oe = 1'b1;
      end else if (i_pwm_own && !i_dir) begin
         o_owner = pemx_pkg::PEMX_OWN_PWM;
         o_out = i_pwm_out;
         o_oe = ~i_pwm_tristate;
      end else if (i_ccp_own && !i_dir) begin
         o_owner = pemx_pkg::PEMX_OWN_CCP;
         o_out = i_ccp_out;
         o_oe = 1'b1;
      end
      if (i_open_drain && (o_owner == pemx_pkg::PEMX_OWN_PWM ||
                           o_owner == pemx_pkg::PEMX_OWN_CCP)) begin
         o_oe = o_oe & ~o_out;
         o_out = 1'b0;
      end
   end
endmodule : pemx_pin_sel
`default_nettype wire

/* verilog/pemx_regs.sv */
/*
 * Direction, latch and pad configuration storage for the port.
 * Assumes write strobes are single-cycle pulses in the system clock.
 */
`timescale 1ns/1ps
`default_nettype none
module pemx_regs (
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire logic i_dir_we,
   input wire logic [7:0] i_dir_wdata,
   input wire logic i_latch_we,
   input wire logic [7:0] i_latch_wdata,
   input wire logic i_pad_we,
   input wire logic [7:0] i_pad_wdata,
   input wire logic i_od_we,
   input wire logic [7:0] i_od_wdata,
   output logic [7:0] o_dir,
   output logic [7:0] o_latch,
   output logic o_pullup_dis,
   output logic o_open_drain
);
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         o_dir <= pemx_pkg::DIR_RESET;
      end else if (i_dir_we) begin
         o_dir <= i_dir_wdata;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         o_latch <= pemx_pkg::LATCH_RESET;
      end else if (i_latch_we) begin
         o_latch <= i_latch_wdata;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         o_pullup_dis <= pemx_pkg::PULLUP_DIS_RESET;
      end else if (i_pad_we) begin
         o_pullup_dis <= i_pad_wdata[pemx_pkg::PULLUP_DIS_BIT];
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         o_open_drain <= pemx_pkg::OPEN_DRAIN_RESET;
      end else if (i_od_we) begin
         o_open_drain <= i_od_wdata[pemx_pkg::OPEN_DRAIN_BIT];
      end
   end
endmodule : pemx_regs
`default_nettype wire

/* verilog/pemx_port.sv */
/*
 * Eight-bit bidirectional port with shared peripheral pins: direction,
 * latch, pin read-back, weak pull-ups, open drain on the top unit-two pin.
 * Assumes pins arrive synchronous to i_clock; peripherals only attach
 * through their ownership, data and tri-state requests.
 */
// Notes on behaviour
// - eight-bit port, direction and latch registers.
// - direction zero drives latch, one reads.
// - open-drain bit makes top unit-two pin low-only.
// - every reset makes all pins inputs.
// - one disable bit kills all pull-ups.
// - output pins never have pull-up on.
// - pull-ups off after any reset.
// - default PWM outputs on bits six to zero.
// - 80-pin map bit moves units one, three.
// - map bit puts unit two on top pin in microcontroller mode.
// - host strobes bits zero to two, direction ignored.
// - bit three may be forced clock output.
// - compare output overrides latch; input feeds capture.
// - PWM outputs tri-state during shutdown.
// - memory bus bits own pins, own direction.
// - slave port only in microcontroller mode.
`timescale 1ns/1ps
`default_nettype none
module pemx_port (
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire logic i_dir_we,
   input wire logic [7:0] i_dir_wdata,
   input wire logic i_latch_we,
   input wire logic [7:0] i_latch_wdata,
   input wire logic i_pad_we,
   input wire logic [7:0] i_pad_wdata,
   input wire logic i_od_we,
   input wire logic [7:0] i_od_wdata,
   input wire logic i_pwm_pin_map_select,
   input wire logic i_unit2_pin_map_select,
   input wire logic i_is_80_pin,
   input wire logic i_mcu_mode,
   input wire logic i_mem_enable,
   input wire logic [7:0] i_mem_oe,
   input wire logic [7:0] i_mem_out,
   input wire logic i_psp_enable,
   input wire logic i_ref_enable,
   input wire logic i_ref_clock,
   input wire logic [3:0] i_unit2_pwm_own,
   input wire logic [3:0] i_unit2_pwm_out,
   input wire logic [1:0] i_unit1_pwm_own,
   input wire logic [1:0] i_unit1_pwm_out,
   input wire logic [1:0] i_unit3_pwm_own,
   input wire logic [1:0] i_unit3_pwm_out,
   input wire logic [2:0] i_pwm_shutdown,
   input wire logic [2:0] i_pwm_tristate_en,
   input wire logic [7:0] i_ccp_own,
   input wire logic [7:0] i_ccp_out,
   input wire logic [7:0] i_pin_in,
   output logic [7:0] o_pin_out,
   output logic [7:0] o_pin_oe,
   output logic [7:0] o_pullup_en,
   output logic [7:0] o_port_e_pin_levels,
   output logic [7:0] o_latch,
   output logic [7:0] o_port_e_direction,
   output logic [7:0] o_capture_in,
   output logic [7:0] o_mem_in,
   output logic [2:0] o_psp_strobes,
   output logic o_pullup_dis
);
   // ==================================================
   // Register storage
   logic [7:0] dir_reg;
   logic [7:0] latch_reg;
   logic pullup_dis_reg;
   logic od_reg;

   pemx_regs u_regs (
      .i_clock(i_clock),
      .i_sys_rst(i_sys_rst),
      .i_dir_we(i_dir_we),
      .i_dir_wdata(i_dir_wdata),
      .i_latch_we(i_latch_we),
      .i_latch_wdata(i_latch_wdata),
      .i_pad_we(i_pad_we),
      .i_pad_wdata(i_pad_wdata),
      .i_od_we(i_od_we),
      .i_od_wdata(i_od_wdata),
      .o_dir(dir_reg),
      .o_latch(latch_reg),
      .o_pullup_dis(pullup_dis_reg),
      .o_open_drain(od_reg)
   );

   // ==================================================
   // Peripheral request mapping
   logic [7:0] pwm_own;
   logic [7:0] pwm_out;
   logic [7:0] pwm_tri;
   logic [7:0] ccp_own;
   logic [7:0] ccp_out;
   logic psp_ok;
   logic unit13_here;
   logic unit2_top;

   // Slave port and unit-two remap qualified by mode.
   always_comb begin
      psp_ok = i_psp_enable & i_mcu_mode & ~i_mem_enable;
      unit13_here = ~(i_is_80_pin & ~i_pwm_pin_map_select);
      unit2_top = i_mcu_mode & ~i_unit2_pin_map_select;
   end

   // Maps each PWM unit output to its pin on this port.
   always_comb begin
      pwm_own = 8'h00;
      pwm_out = 8'h00;
      pwm_tri = 8'h00;
      pwm_own[2:0] = {i_unit2_pwm_own[1], i_unit2_pwm_own[2], i_unit2_pwm_own[3]};
      pwm_out[2:0] = {i_unit2_pwm_out[1], i_unit2_pwm_out[2], i_unit2_pwm_out[3]};
      pwm_tri[2:0] = {3{i_pwm_shutdown[1] & i_pwm_tristate_en[1]}};
      if (unit13_here) begin
         pwm_own[4:3] = {i_unit3_pwm_own[0], i_unit3_pwm_own[1]};
         pwm_out[4:3] = {i_unit3_pwm_out[0], i_unit3_pwm_out[1]};
         pwm_tri[4:3] = {2{i_pwm_shutdown[2] & i_pwm_tristate_en[2]}};
         pwm_own[6:5] = {i_unit1_pwm_own[0], i_unit1_pwm_own[1]};
         pwm_out[6:5] = {i_unit1_pwm_out[0], i_unit1_pwm_out[1]};
         pwm_tri[6:5] = {2{i_pwm_shutdown[0] & i_pwm_tristate_en[0]}};
      end
      if (unit2_top) begin
         pwm_own[pemx_pkg::PIN_TOP] = i_unit2_pwm_own[0];
         pwm_out[pemx_pkg::PIN_TOP] = i_unit2_pwm_out[0];
         pwm_tri[pemx_pkg::PIN_TOP] = i_pwm_shutdown[1] & i_pwm_tristate_en[1];
      end
   end

   // Capture/compare channels; the top pin's channel exists only when remapped.
   always_comb begin
      ccp_own = i_ccp_own;
      ccp_out = i_ccp_out;
      ccp_own[pemx_pkg::PIN_TOP] = i_ccp_own[pemx_pkg::PIN_TOP] & unit2_top;
   end

   // ==================================================
   // Per-pin selectors
   logic [7:0] drv_out;
   logic [7:0] drv_oe;
   pemx_pkg::pemx_owner_t owner [8];

   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_pin
         pemx_pin_sel u_sel (
            .i_dir(dir_reg[g]),
            .i_latch(latch_reg[g]),
            .i_mem_oe(i_mem_enable & i_mem_oe[g]),
            .i_mem_out(i_mem_enable & i_mem_out[g]),
            .i_psp_own(psp_ok && g <= pemx_pkg::PIN_CS),
            .i_ref_own(i_ref_enable && g == pemx_pkg::PIN_REFCLK),
            .i_ref_out(i_ref_clock),
            .i_pwm_own(pwm_own[g]),
            .i_pwm_out(pwm_out[g]),
            .i_pwm_tristate(pwm_tri[g]),
            .i_ccp_own(ccp_own[g]),
            .i_ccp_out(ccp_out[g]),
            .i_open_drain(od_reg && g == pemx_pkg::PIN_TOP && unit2_top),
            .o_owner(owner[g]),
            .o_out(drv_out[g]),
            .o_oe(drv_oe[g])
         );
      end
   endgenerate

   // Memory data is driven only when the memory bus enables that bit.
   logic [7:0] final_out;
   logic [7:0] final_oe;
   always_comb begin
      final_out = i_mem_enable ? (i_mem_out & i_mem_oe) | (drv_out & ~i_mem_oe) : drv_out;
      final_oe = i_mem_enable ? i_mem_oe : drv_oe;
   end

   // ==================================================
   // Registered pad outputs
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         o_pin_out <= pemx_pkg::LATCH_RESET;
         o_pin_oe <= 8'h00;
      end else begin
         o_pin_out <= final_out;
         o_pin_oe <= final_oe;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         o_pullup_en <= 8'h00;
      end else begin
         o_pullup_en <= {8{~pullup_dis_reg}} & ~final_oe;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         o_port_e_pin_levels <= pemx_pkg::LEVELS_RESET;
         o_capture_in <= 8'h00;
         o_mem_in <= 8'h00;
         o_psp_strobes <= 3'h0;
      end else begin
         o_port_e_pin_levels <= i_pin_in;
         o_capture_in <= i_pin_in & dir_reg & ccp_own;
         o_mem_in <= i_mem_enable ? i_pin_in : 8'h00;
         o_psp_strobes <= psp_ok ? i_pin_in[2:0] : 3'h0;
      end
   end

   // Register read-back copies.
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         o_latch <= pemx_pkg::LATCH_RESET;
         o_port_e_direction <= pemx_pkg::DIR_RESET;
         o_pullup_dis <= pemx_pkg::PULLUP_DIS_RESET;
      end else begin
         o_latch <= latch_reg;
         o_port_e_direction <= dir_reg;
         o_pullup_dis <= pullup_dis_reg;
      end
   end

   // ==================================================
   // Assertions
   property p_reset_inputs;
      @(posedge i_clock) $past(i_sys_rst) |-> o_pin_oe == 8'h00 && o_port_e_direction == 8'hFF;
   endproperty
   a_reset_inputs: assert property (p_reset_inputs) else $error("pins not inputs after reset");

   property p_pullup_output;
      @(posedge i_clock) disable iff (i_sys_rst) (o_pullup_en & o_pin_oe) == 8'h00;
   endproperty
   a_pullup_output: assert property (p_pullup_output) else $error("pull-up on driven pin");

   property p_pullup_dis;
      @(posedge i_clock) disable iff (i_sys_rst)
         o_pullup_dis |-> o_pullup_en == 8'h00;
   endproperty
   a_pullup_dis: assert property (p_pullup_dis) else $error("pull-up disable ignored");

   property p_pullup_reset;
      @(posedge i_clock) $past(i_sys_rst) |-> o_pullup_en == 8'h00;
   endproperty
   a_pullup_reset: assert property (p_pullup_reset) else $error("pull-up on after reset");

   property p_latch_drive;
      @(posedge i_clock) disable iff (i_sys_rst)
         (!i_mem_enable && !psp_ok && !i_ref_enable && pwm_own == 8'h00 &&
          ccp_own == 8'h00) |=> o_pin_oe == ~$past(dir_reg) && o_pin_out == $past(latch_reg);
   endproperty
   a_latch_drive: assert property (p_latch_drive) else $error("latch not driven");

   property p_ref_drive;
      @(posedge i_clock) disable iff (i_sys_rst)
         (i_ref_enable && !i_mem_enable && !psp_ok) |=> o_pin_oe[3];
   endproperty
   a_ref_drive: assert property (p_ref_drive) else $error("clock output not driven");

   property p_psp_float;
      @(posedge i_clock) disable iff (i_sys_rst) psp_ok |=> o_pin_oe[2:0] == 3'h0;
   endproperty
   a_psp_float: assert property (p_psp_float) else $error("strobe pin driven");

   property p_open_drain;
      @(posedge i_clock) disable iff (i_sys_rst)
         (od_reg && unit2_top && !i_mem_enable && owner[7] != pemx_pkg::PEMX_OWN_LATCH)
            |=> !(o_pin_oe[7] && o_pin_out[7]);
   endproperty
   a_open_drain: assert property (p_open_drain) else $error("open drain drove high");

   property p_mem_dir;
      @(posedge i_clock) disable iff (i_sys_rst) i_mem_enable |=> o_pin_oe == $past(i_mem_oe);
   endproperty
   a_mem_dir: assert property (p_mem_dir) else $error("memory direction ignored");
endmodule : pemx_port
`default_nettype wire

/* verif/pemx_board_model.sv */
/*
 * Board side of the port pins: pad wires, weak pull-ups and an external host.
 * Assumes pad drive and enable come registered from the port in one clock.
 */
`timescale 1ns/1ps
`default_nettype none
module pemx_board_model (
   input wire logic i_clock,
   input wire logic [7:0] i_pin_out,
   input wire logic [7:0] i_pin_oe,
   input wire logic [7:0] i_pullup_en,
   input wire logic [7:0] i_ext_en,
   input wire logic [7:0] i_ext_val,
   output logic [7:0] o_pin_in
);
   // =========================================================
   // Floating pads
   logic [7:0] float_reg = 8'hA5;

   // An undriven pad without pull-up changes every cycle, so it never looks stable.
   always @(posedge i_clock) begin
      float_reg <= ~float_reg;
   end

   // =========================================================
   // Wire level
   // host strobes, pull-ups
   // The host drives only pads the port has released, which avoids contention.
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (i_pin_oe[i]) o_pin_in[i] = i_pin_out[i];
         else if (i_ext_en[i]) o_pin_in[i] = i_ext_val[i];
         else if (i_pullup_en[i]) o_pin_in[i] = 1'h1;
         else o_pin_in[i] = float_reg[i];
      end
   end
endmodule : pemx_board_model
`default_nettype wire

/* verif/testbench.sv */
/*
 * Self-checking bench for the port: random configurations are written and
 * checked against a reference of pin ownership once the pads have settled.
 * Assumes the board model stands on the pins and makes the pad levels.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench;
   typedef struct packed {
      logic [7:0] oe, drv, pu, um, lev, kn, cap, lat, dir;
      logic pudis, memv, pspv;
   } pemx_note_t;
   logic i_clock = 1'h0;
   logic i_sys_rst;
   logic dir_we, latch_we, pad_we, od_we, pwm_map, u2_map, is80, mcu;
   logic mem_en, psp_en, ref_en, ref_clk, s_pudis, s_od, pudis_o;
   logic [7:0] dir_wd, lat_wd, pad_wd, od_wd, mem_oe, mem_out, ccp_own, ccp_out;
   logic [7:0] pin_in, pin_out, pin_oe, pu_en, lev, lat_o, dir_o, cap, mem_in;
   logic [7:0] ext_en, ext_val, s_dir, s_lat;
   logic [3:0] u2_own, u2_out;
   logic [1:0] u1_own, u1_out, u3_own, u3_out;
   logic [2:0] sd, tri_en, strobes;
   logic [31:0] r;
   integer seed = 32'hEA0D8508;
   int num_errors = 0;
   int comparisons = 0;
   pemx_note_t note_q[$];
   pemx_note_t cur;

   // =========================================================
   // Clock, design and board
   // The clock toggles every half period of 12.5 ns.
   always #12.5 i_clock = ~i_clock;

   pemx_port dut_u (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_dir_we(dir_we),
      .i_dir_wdata(dir_wd), .i_latch_we(latch_we), .i_latch_wdata(lat_wd),
      .i_pad_we(pad_we), .i_pad_wdata(pad_wd), .i_od_we(od_we), .i_od_wdata(od_wd),
      .i_pwm_pin_map_select(pwm_map), .i_unit2_pin_map_select(u2_map),
      .i_is_80_pin(is80), .i_mcu_mode(mcu), .i_mem_enable(mem_en), .i_mem_oe(mem_oe),
      .i_mem_out(mem_out), .i_psp_enable(psp_en), .i_ref_enable(ref_en),
      .i_ref_clock(ref_clk), .i_unit2_pwm_own(u2_own), .i_unit2_pwm_out(u2_out),
      .i_unit1_pwm_own(u1_own), .i_unit1_pwm_out(u1_out), .i_unit3_pwm_own(u3_own),
      .i_unit3_pwm_out(u3_out), .i_pwm_shutdown(sd), .i_pwm_tristate_en(tri_en),
      .i_ccp_own(ccp_own), .i_ccp_out(ccp_out), .i_pin_in(pin_in), .o_pin_out(pin_out),
      .o_pin_oe(pin_oe), .o_pullup_en(pu_en), .o_port_e_pin_levels(lev), .o_latch(lat_o),
      .o_port_e_direction(dir_o), .o_capture_in(cap), .o_mem_in(mem_in),
      .o_psp_strobes(strobes), .o_pullup_dis(pudis_o));

   pemx_board_model board_u (.i_clock(i_clock), .i_pin_out(pin_out), .i_pin_oe(pin_oe),
      .i_pullup_en(pu_en), .i_ext_en(ext_en), .i_ext_val(ext_val), .o_pin_in(pin_in));

   // =========================================================
   // Reference of pin ownership
   function automatic pemx_note_t predict();
      pemx_note_t n;
      logic remap, moved, pspv;
      logic [2:0] tr;
      logic [7:0] oe, drv, pown, pout, ptri, cc, pw;
      remap = !u2_map && mcu;
      moved = !pwm_map && is80;
      pspv = psp_en && mcu && !mem_en;
      tr = sd & tri_en;
      pown = {u2_own[0] & remap, u1_own[0] & !moved, u1_own[1] & !moved,
         u3_own[0] & !moved, u3_own[1] & !moved, u2_own[1], u2_own[2], u2_own[3]};
      pout = {u2_out[0], u1_out[0], u1_out[1], u3_out[0], u3_out[1], u2_out[1], u2_out[2],
         u2_out[3]};
      ptri = {tr[1], tr[0], tr[0], tr[2], tr[2], tr[1], tr[1], tr[1]};
      oe = ~s_dir;
      drv = s_lat;
      cc = ccp_own & ~s_dir & {remap, 7'h7F};
      oe = oe | cc;
      drv = (drv & ~cc) | (ccp_out & cc);
      pw = pown & ~s_dir;
      oe = (oe & ~pw) | (~ptri & pw);
      drv = (drv & ~pw) | (pout & pw);
      if (s_od && remap && !s_dir[7] && (pown[7] || ccp_own[7])) oe[7] = oe[7] & !drv[7];
      if (ref_en) {oe[3], drv[3]} = {1'h1, ref_clk};
      if (pspv) oe[2:0] = 3'h0;
      if (mem_en) {oe, drv} = {mem_oe, mem_out};
      n.oe = oe;
      n.drv = drv & oe;
      n.pu = ~{8{s_pudis}} & s_dir & ~oe;
      n.um = ~(oe ^ ~s_dir);
      n.lev = (oe & drv) | (~oe & ext_en & ext_val) | (~oe & ~ext_en);
      n.kn = oe | ext_en | (n.pu & n.um);
      n.cap = n.lev & s_dir & ccp_own & {remap, 7'h7F};
      {n.lat, n.dir, n.pudis, n.memv, n.pspv} = {s_lat, s_dir, s_pudis, mem_en, pspv};
      return n;
   endfunction : predict

   // =========================================================
   // Stimulus
   task automatic upd();
      if (dir_we) s_dir = dir_wd;
      if (latch_we) s_lat = lat_wd;
      if (pad_we) s_pudis = pad_wd[pemx_pkg::PULLUP_DIS_BIT];
      if (od_we) s_od = od_wd[pemx_pkg::OPEN_DRAIN_BIT];
   endtask : upd

   task automatic zero_inputs();
      {dir_we, latch_we, pad_we, od_we, dir_wd, lat_wd, pad_wd, od_wd} = 36'h0;
      {pwm_map, u2_map, is80, mcu, mem_en, psp_en, ref_en, ref_clk} = 8'h00;
      {mem_oe, mem_out, ccp_own, ccp_out, ext_en, ext_val} = 48'h0;
      {u2_own, u2_out, u1_own, u1_out, u3_own, u3_out, sd, tri_en} = 22'h0;
   endtask : zero_inputs

   task automatic do_reset();
      @(negedge i_clock);
      zero_inputs();
      i_sys_rst = 1'h1;
      {s_dir, s_lat, s_pudis, s_od} = {pemx_pkg::DIR_RESET, pemx_pkg::LATCH_RESET, 2'h2};
      repeat (6) @(negedge i_clock);
      i_sys_rst = 1'h0;
      repeat (3) @(negedge i_clock);
      note_q.push_back(predict());
   endtask : do_reset

   // One random configuration, with a back-to-back direction write at times.
   task automatic step();
      @(negedge i_clock);
      r = $random(seed);
      {pwm_map, u2_map, is80, mcu, psp_en, ref_en, ref_clk} = r[6:0];
      mem_en = (r[9:7] == 3'h0);
      {dir_we, latch_we, pad_we, od_we} = r[13:10];
      {mem_oe, mem_out, ccp_own, ccp_out} = $random(seed);
      r = $random(seed);
      {u2_own, u2_out, u1_own, u1_out, u3_own, u3_out, sd, tri_en} = r[21:0];
      {ext_en, ext_val} = r[31:16] ^ 16'h3C5A;
      {dir_wd, lat_wd, pad_wd, od_wd} = $random(seed);
      upd();
      @(negedge i_clock);
      r = $random(seed);
      {latch_we, pad_we, od_we} = 3'h0;
      {dir_we, dir_wd} = r[8:0];
      upd();
      @(negedge i_clock);
      dir_we = 1'h0;
      repeat (3) @(negedge i_clock);
      note_q.push_back(predict());
   endtask : step

   // =========================================================
   // Checking and verdict
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic give_verdict();
      if (num_errors == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : give_verdict

   // The watcher takes the oldest note once the outputs have settled.
   always @(negedge i_clock) begin
      #1;
      if (note_q.size() > 0) begin
         cur = note_q.pop_front();
         check(pin_oe, cur.oe);
         check(pin_out & cur.oe, cur.drv);
         check(pu_en & cur.um, cur.pu & cur.um);
         check(lev & cur.kn, cur.lev & cur.kn);
         check(cap & cur.kn, cur.cap & cur.kn);
         check(lat_o, cur.lat);
         check(dir_o, cur.dir);
         check({7'h00, pudis_o}, {7'h00, cur.pudis});
         if (cur.memv) check(mem_in & cur.kn, cur.lev & cur.kn);
         else check(mem_in, 8'h00);
         if (cur.pspv) check({5'h00, strobes & cur.kn[2:0]}, {5'h00, cur.lev[2:0] & cur.kn[2:0]});
         else check({5'h00, strobes}, 8'h00);
      end
   end

   // A hang is cut short here.
   initial begin
      repeat (100000) @(posedge i_clock);
      num_errors++;
      give_verdict();
   end

   // Main sequence with a second reset in mid-run.
   initial begin
      zero_inputs();
      i_sys_rst = 1'h1;
      do_reset();
      repeat (300) step();
      do_reset();
      repeat (100) step();
      repeat (4) @(negedge i_clock);
      give_verdict();
   end
endmodule : testbench
`default_nettype wire
